/* File: src/fce_defines.vh */
// Register map, field layout, reset values and codes of the fault-check bank
`ifndef FCE_DEFINES_VH
`define FCE_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define FCE_IDX_OV_EN      6'h1a
`define FCE_IDX_UV_EN      6'h1b
`define FCE_IDX_AUX_EN     6'h1c
`define FCE_IDX_CELL_AOV   6'h20
`define FCE_IDX_CELL_AUV   6'h21
`define FCE_IDX_CELL_COV   6'h22
`define FCE_IDX_CELL_CUV   6'h23
`define FCE_IDX_BLK_AUX    6'h24
`define FCE_IDX_MODE       6'h25
`define FCE_IDX_INT_STAT   6'h26
`define FCE_IDX_INT_MASK   6'h27
`define FCE_ADDR_W         8

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define FCE_CELLS          14
`define FCE_AUXS           6
`define FCE_BLK_BIT        14
`define FCE_I2C_CHANS      2
`define FCE_MODE_GPIO_LSB  0
`define FCE_MODE_I2C_BIT   6
`define FCE_MODE_REF_LSB   8
`define FCE_BA_BLK_OV_BIT  0
`define FCE_BA_BLK_UV_BIT  1
`define FCE_BA_AUX_LSB     2
`define FCE_INTS           5
`define FCE_INT_CELL_OV    0
`define FCE_INT_CELL_UV    1
`define FCE_INT_BLK_OV     2
`define FCE_INT_BLK_UV     3
`define FCE_INT_AUX_COLD   4
`define FCE_VAL_W          16

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FCE_RST_CELL_EN    14'h0000
`define FCE_RST_AUX_EN     6'h00
`define FCE_RST_MODE_GPIO  6'h00
`define FCE_RST_MODE_REF   6'h00
`define FCE_RST_INT_MASK   5'h00

// ----------------------------------------------------------------------------
// Scan result target codes
// ----------------------------------------------------------------------------
`define FCE_TGT_CELL       2'h0
`define FCE_TGT_BLOCK      2'h1
`define FCE_TGT_AUX        2'h2

`endif

/* File: src/fce_limit_check.v */
// Window comparator of one measurement against a high and a low limit
`include "fce_defines.vh"

module fce_limit_check (
    // Measurement
    input  wire [`FCE_VAL_W-1:0] value,
    // Limits
    input  wire [`FCE_VAL_W-1:0] high_limit,
    input  wire [`FCE_VAL_W-1:0] low_limit,
    input  wire                  low_used,
    // Results
    output wire                  above,
    output wire                  below
);

    // ------------------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------------------
    // Strict compares, a value equal to a limit is no fault
    assign above = (value > high_limit);
    assign below = low_used & (value < low_limit);

endmodule

/* File: src/fce_regs.v */
// Fault-check enable bank with alert latches on an APB slave
`include "fce_defines.vh"

// Notes on behaviour
// RULE1 - Enabled checks are evaluated on each scan result using the ADC or comparator result as the scan reports.
// RULE2 - Block overvoltage enable bit 14 compares ADC block results to the block high limit and latches a block high alert.
// RULE3 - Block undervoltage enable bit 14 compares ADC block results to the block low limit and latches a block low alert.
// RULE4 - Clearing a block enable bit by a write clears the matching latched block alert.
// RULE5 - Overvoltage enable bits 13:0 each enable one cell against the ADC and comparator high limits.
// RULE6 - Undervoltage enable bits 13:0 each enable one cell against the ADC and comparator low limits.
// RULE7 - Clearing a cell enable bit clears that cell's alert in both the ADC and comparator alert status.
// RULE8 - Aux enable bits 5:0 enable cold checks with ratiometric or absolute limits per reference select.
// RULE9 - Clearing an aux enable bit clears that channel's cold alert.
// RULE10 - A channel in general-purpose pin mode ignores its aux enable, which still reads back as written.
// RULE11 - Two-wire mode ignores the aux enables of channels 1:0 only, which still read back as written.
// RULE12 - Unassigned bits read zero and ignore writes, and all enables reset to disabled.
module fce_regs (
    // Clock and reset
    input  wire                  pclk,
    input  wire                  presetn,
    // APB slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [`FCE_ADDR_W-1:0] paddr,
    input  wire [31:0]           pwdata,
    output wire [31:0]           prdata,
    output wire                  pready,
    output wire                  pslverr,
    // Scan results
    input  wire                  scan_valid,
    input  wire                  scan_engine_comp,
    input  wire [1:0]            scan_target,
    input  wire [3:0]            scan_channel,
    input  wire [`FCE_VAL_W-1:0] scan_value,
    // Limits
    input  wire [`FCE_VAL_W-1:0] cell_high_limit_adc,
    input  wire [`FCE_VAL_W-1:0] cell_low_limit_adc,
    input  wire [`FCE_VAL_W-1:0] cell_high_limit_comparator,
    input  wire [`FCE_VAL_W-1:0] cell_low_limit_comparator,
    input  wire [`FCE_VAL_W-1:0] block_high_limit,
    input  wire [`FCE_VAL_W-1:0] block_low_limit,
    input  wire [`FCE_VAL_W-1:0] aux_ratio_cold_limit_adc,
    input  wire [`FCE_VAL_W-1:0] aux_abs_cold_limit_adc,
    input  wire [`FCE_VAL_W-1:0] aux_ratio_cold_limit_comparator,
    input  wire [`FCE_VAL_W-1:0] aux_abs_cold_limit_comparator,
    // Alerts
    output wire [`FCE_CELLS-1:0] cell_adc_high_alert,
    output wire [`FCE_CELLS-1:0] cell_adc_low_alert,
    output wire [`FCE_CELLS-1:0] cell_comp_high_alert,
    output wire [`FCE_CELLS-1:0] cell_comp_low_alert,
    output wire                  block_high_alert,
    output wire                  block_low_alert,
    output wire [`FCE_AUXS-1:0]  aux_cold_alert,
    output wire                  irq
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [`FCE_CELLS-1:0] cell_high_check_on_reg;
    reg  [`FCE_CELLS-1:0] cell_low_check_on_reg;
    reg                   block_high_check_on_reg;
    reg                   block_low_check_on_reg;
    reg  [`FCE_AUXS-1:0]  aux_cold_check_on_reg;
    reg  [`FCE_AUXS-1:0]  pin_general_purpose_mode_reg;
    reg                   two_wire_mode_enable_reg;
    reg  [`FCE_AUXS-1:0]  aux_reference_select_reg;
    reg  [`FCE_CELLS-1:0] cell_aov_reg;
    reg  [`FCE_CELLS-1:0] cell_auv_reg;
    reg  [`FCE_CELLS-1:0] cell_cov_reg;
    reg  [`FCE_CELLS-1:0] cell_cuv_reg;
    reg                   blk_ov_reg;
    reg                   blk_uv_reg;
    reg  [`FCE_AUXS-1:0]  aux_ov_reg;
    reg  [`FCE_INTS-1:0]  int_stat_reg;
    reg  [`FCE_INTS-1:0]  int_mask_reg;
    reg  [31:0]           rdata_reg;
    reg  [31:0]           rdata_next;
    reg                   hit_next;
    reg                   hit_reg;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    wire       setup   = psel & ~penable;
    wire       access  = psel & penable;
    wire       aligned = (paddr[1:0] == 2'b00);
    wire [5:0] idx     = paddr[`FCE_ADDR_W-1:2];

    // Always ready, data captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~hit_reg;
    assign prdata  = rdata_reg;

    wire wr      = access & pwrite & hit_reg;
    wire wr_ov   = wr & (idx == `FCE_IDX_OV_EN);
    wire wr_uv   = wr & (idx == `FCE_IDX_UV_EN);
    wire wr_aux  = wr & (idx == `FCE_IDX_AUX_EN);
    wire wr_mode = wr & (idx == `FCE_IDX_MODE);
    wire wr_mask = wr & (idx == `FCE_IDX_INT_MASK);
    wire rd_int  = access & ~pwrite & hit_reg & (idx == `FCE_IDX_INT_STAT);

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        rdata_next = 32'h0000_0000;
        hit_next   = aligned;
        case (idx)
            `FCE_IDX_OV_EN: begin
                rdata_next[`FCE_CELLS-1:0] = cell_high_check_on_reg;
                rdata_next[`FCE_BLK_BIT]   = block_high_check_on_reg;
            end
            `FCE_IDX_UV_EN: begin
                rdata_next[`FCE_CELLS-1:0] = cell_low_check_on_reg;
                rdata_next[`FCE_BLK_BIT]   = block_low_check_on_reg;
            end
            // Stored value reads back whatever the pin mode
            `FCE_IDX_AUX_EN: // RULE10 RULE11
                rdata_next[`FCE_AUXS-1:0] = aux_cold_check_on_reg;
            `FCE_IDX_CELL_AOV: rdata_next[`FCE_CELLS-1:0] = cell_aov_reg;
            `FCE_IDX_CELL_AUV: rdata_next[`FCE_CELLS-1:0] = cell_auv_reg;
            `FCE_IDX_CELL_COV: rdata_next[`FCE_CELLS-1:0] = cell_cov_reg;
            `FCE_IDX_CELL_CUV: rdata_next[`FCE_CELLS-1:0] = cell_cuv_reg;
            `FCE_IDX_BLK_AUX: begin
                rdata_next[`FCE_BA_BLK_OV_BIT] = blk_ov_reg;
                rdata_next[`FCE_BA_BLK_UV_BIT] = blk_uv_reg;
                rdata_next[`FCE_BA_AUX_LSB +: `FCE_AUXS] = aux_ov_reg;
            end
            `FCE_IDX_MODE: begin
                rdata_next[`FCE_MODE_GPIO_LSB +: `FCE_AUXS] =
                    pin_general_purpose_mode_reg;
                rdata_next[`FCE_MODE_I2C_BIT] = two_wire_mode_enable_reg;
                rdata_next[`FCE_MODE_REF_LSB +: `FCE_AUXS] =
                    aux_reference_select_reg;
            end
            `FCE_IDX_INT_STAT: rdata_next[`FCE_INTS-1:0] = int_stat_reg;
            `FCE_IDX_INT_MASK: rdata_next[`FCE_INTS-1:0] = int_mask_reg;
            default:           hit_next = 1'b0;
        endcase
        // Unassigned bits above stay zero
        if (!hit_next) begin
            rdata_next = 32'h0000_0000; // RULE12
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            hit_reg   <= 1'b0;
        end else if (setup) begin
            rdata_reg <= rdata_next;
            hit_reg   <= hit_next;
        end
    end

    // ------------------------------------------------------------------------
    // Enable and mode registers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_high_check_on_reg       <= `FCE_RST_CELL_EN; // RULE12
            cell_low_check_on_reg        <= `FCE_RST_CELL_EN; // RULE12
            block_high_check_on_reg      <= 1'b0;
            block_low_check_on_reg       <= 1'b0;
            aux_cold_check_on_reg        <= `FCE_RST_AUX_EN; // RULE12
            pin_general_purpose_mode_reg <= `FCE_RST_MODE_GPIO;
            two_wire_mode_enable_reg     <= 1'b0;
            aux_reference_select_reg     <= `FCE_RST_MODE_REF;
            int_mask_reg                 <= `FCE_RST_INT_MASK;
        end else begin
            // Only the defined fields are kept, the rest is dropped
            if (wr_ov) begin
                cell_high_check_on_reg  <= pwdata[`FCE_CELLS-1:0]; // RULE5
                block_high_check_on_reg <= pwdata[`FCE_BLK_BIT]; // RULE2
            end
            if (wr_uv) begin
                cell_low_check_on_reg  <= pwdata[`FCE_CELLS-1:0]; // RULE6
                block_low_check_on_reg <= pwdata[`FCE_BLK_BIT]; // RULE3
            end
            if (wr_aux) begin
                aux_cold_check_on_reg <= pwdata[`FCE_AUXS-1:0]; // RULE8
            end
            if (wr_mode) begin
                pin_general_purpose_mode_reg <=
                    pwdata[`FCE_MODE_GPIO_LSB +: `FCE_AUXS];
                two_wire_mode_enable_reg <= pwdata[`FCE_MODE_I2C_BIT];
                aux_reference_select_reg <=
                    pwdata[`FCE_MODE_REF_LSB +: `FCE_AUXS];
            end
            if (wr_mask) begin
                int_mask_reg <= pwdata[`FCE_INTS-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Enable clear strobes
    // ------------------------------------------------------------------------
    // A one-to-zero write of an enable drops its latched alert
    wire [`FCE_CELLS-1:0] cell_ov_clr = wr_ov ?
        (cell_high_check_on_reg & ~pwdata[`FCE_CELLS-1:0]) :
        `FCE_RST_CELL_EN; // RULE7
    wire [`FCE_CELLS-1:0] cell_uv_clr = wr_uv ?
        (cell_low_check_on_reg & ~pwdata[`FCE_CELLS-1:0]) :
        `FCE_RST_CELL_EN; // RULE7
    wire blk_ov_clr = wr_ov & block_high_check_on_reg &
        ~pwdata[`FCE_BLK_BIT]; // RULE4
    wire blk_uv_clr = wr_uv & block_low_check_on_reg &
        ~pwdata[`FCE_BLK_BIT]; // RULE4
    wire [`FCE_AUXS-1:0] aux_clr = wr_aux ?
        (aux_cold_check_on_reg & ~pwdata[`FCE_AUXS-1:0]) :
        `FCE_RST_AUX_EN; // RULE9

    // ------------------------------------------------------------------------
    // Effective aux enables
    // ------------------------------------------------------------------------
    wire [`FCE_AUXS-1:0] two_wire_mask = {
        {(`FCE_AUXS-`FCE_I2C_CHANS){1'b0}},
        {`FCE_I2C_CHANS{two_wire_mode_enable_reg}}};
    wire [`FCE_AUXS-1:0] aux_live = aux_cold_check_on_reg &
        ~pin_general_purpose_mode_reg & // RULE10
        ~two_wire_mask; // RULE11

    // ------------------------------------------------------------------------
    // Limit selection and compare
    // ------------------------------------------------------------------------
    reg  [`FCE_VAL_W-1:0] sel_high;
    reg  [`FCE_VAL_W-1:0] sel_low;
    reg                   sel_low_used;
    wire                  above;
    wire                  below;
    wire [2:0]            aux_ch = scan_channel[2:0];
    wire aux_ratio = (aux_ch < `FCE_AUXS) ?
        aux_reference_select_reg[aux_ch] : 1'b0;

    always @* begin
        sel_high     = cell_high_limit_adc;
        sel_low      = cell_low_limit_adc;
        sel_low_used = 1'b1;
        case (scan_target)
            `FCE_TGT_CELL: begin
                // Engine of the scan picks the limit pair
                if (scan_engine_comp) begin // RULE1
                    sel_high = cell_high_limit_comparator;
                    sel_low  = cell_low_limit_comparator;
                end
            end
            `FCE_TGT_BLOCK: begin
                sel_high = block_high_limit; // RULE2
                sel_low  = block_low_limit; // RULE3
            end
            `FCE_TGT_AUX: begin
                sel_low_used = 1'b0;
                if (scan_engine_comp) begin // RULE1
                    sel_high = aux_ratio ? aux_ratio_cold_limit_comparator :
                                           aux_abs_cold_limit_comparator;
                end else begin
                    sel_high = aux_ratio ? aux_ratio_cold_limit_adc :
                                           aux_abs_cold_limit_adc; // RULE8
                end
            end
            default: begin
                sel_low_used = 1'b0;
            end
        endcase
    end

    fce_limit_check u_check (
        .value      (scan_value),
        .high_limit (sel_high),
        .low_limit  (sel_low),
        .low_used   (sel_low_used),
        .above      (above),
        .below      (below)
    );

    // ------------------------------------------------------------------------
    // Alert latches
    // ------------------------------------------------------------------------
    wire is_cell  = scan_valid & (scan_target == `FCE_TGT_CELL);
    wire is_adc   = ~scan_engine_comp;
    // Block results come from the ADC only
    wire blk_ov_set = scan_valid & (scan_target == `FCE_TGT_BLOCK) &
        is_adc & block_high_check_on_reg & above; // RULE2
    wire blk_uv_set = scan_valid & (scan_target == `FCE_TGT_BLOCK) &
        is_adc & block_low_check_on_reg & below; // RULE3

    wire [`FCE_CELLS-1:0] aov_set;
    wire [`FCE_CELLS-1:0] auv_set;
    wire [`FCE_CELLS-1:0] cov_set;
    wire [`FCE_CELLS-1:0] cuv_set;
    wire [`FCE_AUXS-1:0]  aux_set;

    wire [15:0] chan_hot = 16'h0001 << scan_channel;
    genvar i;
    generate
        for (i = 0; i < `FCE_CELLS; i = i + 1) begin : g_cell
            wire hit = is_cell & chan_hot[i];
            assign aov_set[i] = hit & is_adc &
                cell_high_check_on_reg[i] & above; // RULE5
            assign auv_set[i] = hit & is_adc &
                cell_low_check_on_reg[i] & below; // RULE6
            assign cov_set[i] = hit & scan_engine_comp &
                cell_high_check_on_reg[i] & above; // RULE5
            assign cuv_set[i] = hit & scan_engine_comp &
                cell_low_check_on_reg[i] & below; // RULE6
        end
        for (i = 0; i < `FCE_AUXS; i = i + 1) begin : g_aux
            assign aux_set[i] = scan_valid & (scan_target == `FCE_TGT_AUX) &
                chan_hot[i] & aux_live[i] & above; // RULE8
        end
    endgenerate

    // A new fault in the clearing cycle survives the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_aov_reg <= `FCE_RST_CELL_EN;
            cell_auv_reg <= `FCE_RST_CELL_EN;
            cell_cov_reg <= `FCE_RST_CELL_EN;
            cell_cuv_reg <= `FCE_RST_CELL_EN;
            blk_ov_reg   <= 1'b0;
            blk_uv_reg   <= 1'b0;
            aux_ov_reg   <= `FCE_RST_AUX_EN;
        end else begin
            cell_aov_reg <= (cell_aov_reg & ~cell_ov_clr) | aov_set; // RULE7
            cell_auv_reg <= (cell_auv_reg & ~cell_uv_clr) | auv_set; // RULE7
            cell_cov_reg <= (cell_cov_reg & ~cell_ov_clr) | cov_set; // RULE7
            cell_cuv_reg <= (cell_cuv_reg & ~cell_uv_clr) | cuv_set; // RULE7
            blk_ov_reg   <= (blk_ov_reg & ~blk_ov_clr) | blk_ov_set; // RULE4
            blk_uv_reg   <= (blk_uv_reg & ~blk_uv_clr) | blk_uv_set; // RULE4
            aux_ov_reg   <= (aux_ov_reg & ~aux_clr) | aux_set; // RULE9
        end
    end

    assign cell_adc_high_alert  = cell_aov_reg;
    assign cell_adc_low_alert   = cell_auv_reg;
    assign cell_comp_high_alert = cell_cov_reg;
    assign cell_comp_low_alert  = cell_cuv_reg;
    assign block_high_alert     = blk_ov_reg;
    assign block_low_alert      = blk_uv_reg;
    assign aux_cold_alert       = aux_ov_reg;

    // ------------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------------
    wire [`FCE_INTS-1:0] int_event;
    assign int_event[`FCE_INT_CELL_OV]  = |(aov_set | cov_set);
    assign int_event[`FCE_INT_CELL_UV]  = |(auv_set | cuv_set);
    assign int_event[`FCE_INT_BLK_OV]   = blk_ov_set;
    assign int_event[`FCE_INT_BLK_UV]   = blk_uv_set;
    assign int_event[`FCE_INT_AUX_COLD] = |aux_set;

    // Clear only what the read returned, so a later event is kept
    wire [`FCE_INTS-1:0] int_clr = rd_int ? rdata_reg[`FCE_INTS-1:0] :
                                            `FCE_RST_INT_MASK;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= `FCE_RST_INT_MASK;
        end else begin
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_event;
        end
    end

    assign irq = |(int_stat_reg & int_mask_reg);

endmodule

/* File: tb/fce_regs_chk.sv */
// Port-level checks of the fault-check enable bank
`include "fce_defines.vh"

module fce_chk (
    // Clock, reset and bus
    input logic                    pclk,
    input logic                    presetn,
    input logic                    psel,
    input logic                    penable,
    input logic                    pwrite,
    input logic [`FCE_ADDR_W-1:0]  paddr,
    input logic [31:0]             pwdata,
    input logic [31:0]             prdata,
    // Scan results and limits
    input logic                    scan_valid,
    input logic                    scan_engine_comp,
    input logic [1:0]              scan_target,
    input logic [3:0]              scan_channel,
    input logic [`FCE_VAL_W-1:0]   scan_value,
    input logic [`FCE_VAL_W-1:0]   cell_high_limit_adc,
    input logic [`FCE_VAL_W-1:0]   block_high_limit,
    // Alerts
    input logic [`FCE_CELLS-1:0]   cell_adc_high_alert,
    input logic [`FCE_CELLS-1:0]   cell_comp_high_alert,
    input logic                    block_high_alert,
    input logic [`FCE_AUXS-1:0]    aux_cold_alert
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Shadow of enables, kept from bus writes since the bank is hidden
    // ----
    logic [14:0] ov_sh;
    logic [5:0]  aux_sh;
    wire         wr = psel && penable && pwrite;
    wire         rd = psel && penable && !pwrite;
    wire         adc = scan_valid && !scan_engine_comp;
    wire         cell_hit = adc && scan_target == 2'h0 && scan_channel < 4'he
                 && ov_sh[scan_channel] && scan_value > cell_high_limit_adc;
    wire         blk_hit = adc && scan_target == 2'h1 && ov_sh[14]
                 && scan_value > block_high_limit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_sh <= 15'h0000;
            aux_sh <= 6'h00;
        end else if (wr && paddr == 8'h68) begin
            ov_sh <= pwdata[14:0];
        end else if (wr && paddr == 8'h70) begin
            aux_sh <= pwdata[5:0];
        end
    end

    // ----
    // Assertions
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cell_high_set: assert property (cell_hit
        |=> cell_adc_high_alert[$past(scan_channel)]) else $error("cell alert");
    a_block_high_set: assert property (blk_hit
        |=> block_high_alert) else $error("block alert not set");
    a_cell_clear: assert property (wr && paddr == 8'h68 && !scan_valid
        |=> ({18'h0, cell_adc_high_alert | cell_comp_high_alert}
        & ~$past(pwdata)) == 32'h0) else $error("cell alert kept");
    a_block_clear: assert property (wr && paddr == 8'h68
        && !pwdata[14] && !scan_valid |=> !block_high_alert)
        else $error("block alert kept");
    a_aux_clear: assert property (wr && paddr == 8'h70 && !scan_valid
        |=> ({26'h0, aux_cold_alert} & ~$past(pwdata)) == 32'h0)
        else $error("aux alert kept");
    a_ov_readback: assert property (rd && paddr == 8'h68
        |-> prdata == {17'h0, ov_sh}) else $error("ov readback");
    a_aux_readback: assert property (rd && paddr == 8'h70
        |-> prdata == {26'h0, aux_sh}) else $error("aux readback");
    a_no_cause: assert property (!scan_valid
        |=> (cell_adc_high_alert & ~$past(cell_adc_high_alert)) == 14'h0)
        else $error("alert without scan");
endmodule

bind fce_regs fce_chk chk_i (.*);

/* File: tb/fce_tb_top.sv */
// Directed bench of the fault-check enable bank over APB
`include "fce_defines.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Signals
    // ----
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        scan_valid, scan_engine_comp, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  scan_target;
    logic [3:0]  scan_channel;
    logic [15:0] scan_value, cell_high_limit_adc, cell_low_limit_adc,
                 cell_high_limit_comparator, cell_low_limit_comparator,
                 block_high_limit, block_low_limit, aux_ratio_cold_limit_adc,
                 aux_abs_cold_limit_adc, aux_ratio_cold_limit_comparator,
                 aux_abs_cold_limit_comparator;
    logic [13:0] cell_adc_high_alert, cell_adc_low_alert, cell_comp_high_alert,
                 cell_comp_low_alert;
    logic        block_high_alert, block_low_alert;
    logic [5:0]  aux_cold_alert;
    int          fail_count = 0;
    int          cmp_count = 0;

    fce_regs uut (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic scan(input logic [1:0] t, input logic [3:0] c,
                        input logic e, input logic [15:0] v);
        scan_valid <= 1'b1;
        scan_target <= t;
        scan_channel <= c;
        scan_engine_comp <= e;
        scan_value <= v;
        @(posedge pclk);
        scan_valid <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is about 115 cycles, so this is ample
    initial begin
        #50us;
        fail_count++;
        give_verdict;
    end

    // ----
    // Tests
    // ----
    initial begin
        {presetn, psel, penable, pwrite, scan_valid, scan_engine_comp} = 6'h0;
        {paddr, pwdata, scan_target, scan_channel, scan_value} = 0;
        cell_high_limit_adc = 16'h0100;
        cell_high_limit_comparator = 16'h0200;
        cell_low_limit_adc = 16'h0080;
        cell_low_limit_comparator = 16'h0070;
        block_high_limit = 16'h1000;
        block_low_limit = 16'h0800;
        aux_ratio_cold_limit_adc = 16'h0300;
        aux_abs_cold_limit_adc = 16'h0400;
        aux_ratio_cold_limit_comparator = 16'h0310;
        aux_abs_cold_limit_comparator = 16'h0410;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(8'h68, 32'h0);
        rdchk(8'h6c, 32'h0);
        rdchk(8'h70, 32'h0);
        apb(1'b1, 8'h68, 32'hffffffff);
        rdchk(8'h68, 32'h7fff);
        apb(1'b1, 8'h70, 32'hffffffff);
        rdchk(8'h70, 32'h3f);
        apb(1'b1, 8'h68, 32'h4001);
        scan(2'h0, 4'h0, 1'b0, 16'h0100);
        chk(cell_adc_high_alert, 32'h0);
        scan(2'h0, 4'h0, 1'b0, 16'h0101);
        scan(2'h0, 4'h1, 1'b0, 16'h0101);
        chk(cell_adc_high_alert, 32'h1);
        scan(2'h0, 4'h0, 1'b1, 16'h0201);
        chk(cell_comp_high_alert, 32'h1);
        scan(2'h1, 4'h0, 1'b0, 16'h1001);
        chk(block_high_alert, 32'h1);
        rdchk(8'h88, 32'h1);
        rdchk(8'h90, 32'h1);
        apb(1'b1, 8'h9c, 32'h1f);
        chk(irq, 32'h1);
        rdchk(8'h98, 32'h5);
        chk(irq, 32'h0);
        apb(1'b1, 8'h9c, 32'h0);
        scan(2'h0, 4'h0, 1'b0, 16'h0101);
        chk(irq, 32'h0);
        rdchk(8'h98, 32'h1);
        apb(1'b1, 8'h68, 32'h0);
        chk(cell_adc_high_alert | cell_comp_high_alert, 32'h0);
        chk(block_high_alert, 32'h0);
        apb(1'b1, 8'h6c, 32'h4002);
        scan(2'h0, 4'h1, 1'b0, 16'h007f);
        scan(2'h0, 4'h1, 1'b1, 16'h006f);
        scan(2'h1, 4'h0, 1'b0, 16'h07ff);
        chk({cell_comp_low_alert, cell_adc_low_alert}, 32'h8002);
        chk(block_low_alert, 32'h1);
        apb(1'b1, 8'h6c, 32'h4000);
        chk({cell_comp_low_alert, cell_adc_low_alert}, 32'h0);
        chk(block_low_alert, 32'h1);
        apb(1'b1, 8'h6c, 32'h0);
        chk(block_low_alert, 32'h0);
        apb(1'b1, 8'h94, 32'h0160);
        rdchk(8'h70, 32'h3f);
        for (int i = 0; i < 6; i++) begin
            scan(2'h2, 4'(i), 1'b0, 16'h0401);
        end
        chk(aux_cold_alert, 32'h1c);
        apb(1'b1, 8'h94, 32'h0100);
        scan(2'h2, 4'h0, 1'b0, 16'h0350);
        scan(2'h2, 4'h1, 1'b0, 16'h0350);
        scan(2'h2, 4'h5, 1'b1, 16'h0400);
        chk(aux_cold_alert, 32'h1d);
        apb(1'b1, 8'h70, 32'h3c);
        chk(aux_cold_alert, 32'h1c);
        apb(1'b0, 8'hfc, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h6a, 32'h4001);
        chk(err, 32'h1);
        rdchk(8'h68, 32'h0);
        give_verdict;
    end
endmodule
